// file: cpu_interrupt_controller.v
// Interrupt controller for the processor core: flags, enables, vectoring,
// shadow context and wake from sleep, with an APB register slave.
// Assumes the core accepts a one-cycle entry pulse at any cycle and
// that all event inputs are synchronous to clk_sys except ext_pin.
//
// Overview of operation
// - Any reset clears global and all other enables; no vectoring follows.
// - A source interrupts only with its enable and global enable; peripheral sources also need group enable.
// - Flags set on their events whatever the enable settings are.
// - Entry flushes prefetch, clears global enable, pushes PC, saves, vectors.
// - With global enable clear, events set flags and still wake from sleep; serviced later.
// - Return pops the PC, restores shadow context and sets global enable.
// - Synchronous sources raise the entry pulse on the second clk_sys edge after their event.
// - The asynchronous pin raises the entry pulse on the fourth clk_sys edge after it changes.
// - The pin flag sets on the third clk_sys edge after the pin changes.
// - Any enabled pending source wakes from sleep, the timer included; enables set before sleeping.
// - On wake, vector if global enable set, else continue after sleep.
// - The instruction after sleep always runs before any vectoring.
// - The external pin gives an edge interrupt enabled by its enable bit.
// - Edge select set picks rising edge, clear picks falling edge.
// - A valid pin edge sets its flag and vectors when enabled.
// - Entry saves W, status bits 2:0 only, bank, pointers and PC latch.
// - Shadow copies are read and written by firmware; edits take effect.
`include "irq_ctrl_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module cpu_interrupt_controller (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        resetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Event sources
  input  wire        tmr0_event,
  input  wire        ioc_pending,
  input  wire [7:0]  periph_event_a,
  input  wire [7:0]  periph_event_b,
  input  wire [7:0]  periph_event_c,
  input  wire        ext_pin,
  // Core sequencer status
  input  wire        core_asleep,
  input  wire        core_instr_done,
  input  wire        core_return,
  input  wire [7:0]  core_w,
  input  wire [7:0]  core_status,
  input  wire [4:0]  core_bank_sel,
  input  wire [31:0] core_pointers,
  input  wire [6:0]  core_pc_high,
  // Core sequencer commands
  output reg         irq_entry,
  output reg  [15:0] vector_addr,
  output reg         pc_pop,
  output reg         ctx_restore,
  output reg  [7:0]  restore_w,
  output reg  [7:0]  restore_status,
  output reg  [4:0]  restore_bank_sel,
  output reg  [31:0] restore_pointers,
  output reg  [6:0]  restore_pc_high,
  output reg         wake_req
);

  localparam ST_RUN       = 1'b0;
  localparam ST_WAKE_WAIT = 1'b1;

  reg [7:0]  irq_control_reg;
  reg [7:0]  periph_flag_reg_a;
  reg [7:0]  periph_flag_reg_b;
  reg [7:0]  periph_flag_reg_c;
  reg [7:0]  periph_enable_reg_a;
  reg [7:0]  periph_enable_reg_b;
  reg [7:0]  periph_enable_reg_c;
  reg        ext_pin_edge_select;
  reg [7:0]  shadow_reg [0:7];
  reg        state_reg;
  reg        sleep_seen_reg;
  reg        pin_meta_reg;
  reg        pin_sync_reg;
  reg        pin_prev_reg;

  wire       wr_access;
  wire       rd_setup;
  wire       global_irq_enable;
  wire       periph_group_irq_enable;
  wire       ext_pin_irq_flag;
  wire       pin_rise;
  wire       pin_fall;
  wire       pin_edge;
  wire       core_terms;
  wire       periph_terms;
  wire       pending;
  wire       take_irq;
  wire [2:0] sh_idx;
  wire [7:0] ctrl_wmask;

  reg  [7:0]  ctrl_next;
  reg  [7:0]  flag_a_next;
  reg  [7:0]  flag_b_next;
  reg  [7:0]  flag_c_next;
  reg  [31:0] rdata_next;
  reg         decode_hit;
  reg  [7:0]  sh_mask;

  assign wr_access = psel & penable & pready & pwrite;
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign sh_idx    = paddr[4:2];

  assign global_irq_enable       = irq_control_reg[`BIT_GLOBAL_EN];
  assign periph_group_irq_enable = irq_control_reg[`BIT_GROUP_EN];
  assign ext_pin_irq_flag        = irq_control_reg[`BIT_PIN_FLAG];

  // Only pin_sync_reg and its delayed copy feed the edge detector
  assign pin_rise = pin_sync_reg & ~pin_prev_reg;
  assign pin_fall = ~pin_sync_reg & pin_prev_reg;
  assign pin_edge = ext_pin_edge_select ? pin_rise : pin_fall;

  assign core_terms =
    (irq_control_reg[`BIT_TIMER_EN] & irq_control_reg[`BIT_TIMER_FLAG]) |
    (irq_control_reg[`BIT_PIN_EN] & ext_pin_irq_flag) |
    (irq_control_reg[`BIT_CHANGE_EN] & irq_control_reg[`BIT_CHANGE_FLAG]);
  assign periph_terms = periph_group_irq_enable &
    (|(periph_flag_reg_a & periph_enable_reg_a) |
     |(periph_flag_reg_b & periph_enable_reg_b) |
     |(periph_flag_reg_c & periph_enable_reg_c));
  // Pending ignores the global enable so it can also drive wake-up
  assign pending = core_terms | periph_terms;

  // No vectoring while asleep or before the post-sleep instruction
  assign take_irq = global_irq_enable & pending & ~irq_entry & ~core_asleep &
                    ~sleep_seen_reg & (state_reg == ST_RUN);

  // Interrupt-on-change flag mirrors its source and is read only
  assign ctrl_wmask = 8'hFE;

  // Next values of software-writable flag registers; events win
  always @* begin
    ctrl_next   = irq_control_reg;
    flag_a_next = periph_flag_reg_a;
    flag_b_next = periph_flag_reg_b;
    flag_c_next = periph_flag_reg_c;
    if (wr_access) begin
      if (paddr == `OFS_IRQ_CONTROL) begin
        ctrl_next = (pwdata[7:0] & ctrl_wmask) |
                    (irq_control_reg & ~ctrl_wmask);
      end else if (paddr == `OFS_PERIPH_FLAG_A) begin
        flag_a_next = pwdata[7:0];
      end else if (paddr == `OFS_PERIPH_FLAG_B) begin
        flag_b_next = pwdata[7:0];
      end else if (paddr == `OFS_PERIPH_FLAG_C) begin
        flag_c_next = pwdata[7:0];
      end
    end
    if (tmr0_event) begin
      ctrl_next[`BIT_TIMER_FLAG] = 1'b1;
    end
    if (pin_edge) begin
      ctrl_next[`BIT_PIN_FLAG] = 1'b1;
    end
    ctrl_next[`BIT_CHANGE_FLAG] = ioc_pending;
    if (take_irq) begin
      ctrl_next[`BIT_GLOBAL_EN] = 1'b0;
    end else if (core_return) begin
      ctrl_next[`BIT_GLOBAL_EN] = 1'b1;
    end
    flag_a_next = flag_a_next | periph_event_a;
    flag_b_next = flag_b_next | periph_event_b;
    flag_c_next = flag_c_next | periph_event_c;
  end

  // Writable bits of each shadow slot
  always @* begin
    if (sh_idx == `SH_STATUS) begin
      sh_mask = `MASK_STATUS;
    end else if (sh_idx == `SH_BANK) begin
      sh_mask = `MASK_BANK;
    end else if (sh_idx == `SH_PC_HIGH) begin
      sh_mask = `MASK_PC_HIGH;
    end else begin
      sh_mask = `MASK_FULL;
    end
  end

  // Read data and decode
  always @* begin
    rdata_next = `RST_WORD;
    decode_hit = 1'b1;
    if (paddr[1:0] != 2'b00) begin
      decode_hit = 1'b0;
    end else if (paddr == `OFS_IRQ_CONTROL) begin
      rdata_next[7:0] = irq_control_reg;
    end else if (paddr == `OFS_PERIPH_FLAG_A) begin
      rdata_next[7:0] = periph_flag_reg_a;
    end else if (paddr == `OFS_PERIPH_FLAG_B) begin
      rdata_next[7:0] = periph_flag_reg_b;
    end else if (paddr == `OFS_PERIPH_FLAG_C) begin
      rdata_next[7:0] = periph_flag_reg_c;
    end else if (paddr == `OFS_PERIPH_EN_A) begin
      rdata_next[7:0] = periph_enable_reg_a;
    end else if (paddr == `OFS_PERIPH_EN_B) begin
      rdata_next[7:0] = periph_enable_reg_b;
    end else if (paddr == `OFS_PERIPH_EN_C) begin
      rdata_next[7:0] = periph_enable_reg_c;
    end else if (paddr == `OFS_EDGE_CFG) begin
      rdata_next[`BIT_EDGE_SEL] = ext_pin_edge_select;
    end else if (paddr >= `OFS_SHADOW_BASE &&
                 paddr <= `OFS_SHADOW_LAST) begin
      rdata_next[7:0] = shadow_reg[sh_idx];
    end else begin
      decode_hit = 1'b0;
    end
  end

  // APB handshake: one setup and one access cycle, no extra waits
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RST_WORD;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~decode_hit;
      if (rd_setup) begin
        prdata <= rdata_next;
      end else if (!psel) begin
        prdata <= `RST_WORD;
      end
    end
  end

  // Pin synchroniser and edge history
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= ext_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Control, flag and enable registers
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_control_reg     <= `RST_BYTE;
      periph_flag_reg_a   <= `RST_BYTE;
      periph_flag_reg_b   <= `RST_BYTE;
      periph_flag_reg_c   <= `RST_BYTE;
      periph_enable_reg_a <= `RST_BYTE;
      periph_enable_reg_b <= `RST_BYTE;
      periph_enable_reg_c <= `RST_BYTE;
      ext_pin_edge_select <= 1'b0;
    end else begin
      irq_control_reg   <= ctrl_next;
      periph_flag_reg_a <= flag_a_next;
      periph_flag_reg_b <= flag_b_next;
      periph_flag_reg_c <= flag_c_next;
      if (wr_access) begin
        if (paddr == `OFS_PERIPH_EN_A) begin
          periph_enable_reg_a <= pwdata[7:0];
        end else if (paddr == `OFS_PERIPH_EN_B) begin
          periph_enable_reg_b <= pwdata[7:0];
        end else if (paddr == `OFS_PERIPH_EN_C) begin
          periph_enable_reg_c <= pwdata[7:0];
        end else if (paddr == `OFS_EDGE_CFG) begin
          ext_pin_edge_select <= pwdata[`BIT_EDGE_SEL];
        end
      end
    end
  end

  // Shadow context: captured on entry, firmware may edit in between
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shadow_reg[`SH_W]       <= `RST_BYTE;
      shadow_reg[`SH_STATUS]  <= `RST_BYTE;
      shadow_reg[`SH_BANK]    <= `RST_BYTE;
      shadow_reg[`SH_PTR0_LO] <= `RST_BYTE;
      shadow_reg[`SH_PTR0_HI] <= `RST_BYTE;
      shadow_reg[`SH_PTR1_LO] <= `RST_BYTE;
      shadow_reg[`SH_PTR1_HI] <= `RST_BYTE;
      shadow_reg[`SH_PC_HIGH] <= `RST_BYTE;
    end else if (take_irq) begin
      shadow_reg[`SH_W]       <= core_w;
      shadow_reg[`SH_STATUS]  <= core_status & `MASK_STATUS;
      shadow_reg[`SH_BANK]    <= {3'b000, core_bank_sel};
      shadow_reg[`SH_PTR0_LO] <= core_pointers[7:0];
      shadow_reg[`SH_PTR0_HI] <= core_pointers[15:8];
      shadow_reg[`SH_PTR1_LO] <= core_pointers[23:16];
      shadow_reg[`SH_PTR1_HI] <= core_pointers[31:24];
      shadow_reg[`SH_PC_HIGH] <= {1'b0, core_pc_high};
    end else if (wr_access && paddr >= `OFS_SHADOW_BASE &&
                 paddr <= `OFS_SHADOW_LAST) begin
      shadow_reg[sh_idx] <= pwdata[7:0] & sh_mask;
    end
  end

  // Wake sequencing: hold off vectoring until one instruction has run
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= ST_RUN;
      sleep_seen_reg <= 1'b0;
    end else begin
      sleep_seen_reg <= core_asleep;
      case (state_reg)
        ST_RUN: begin
          if (sleep_seen_reg && !core_asleep) begin
            state_reg <= ST_WAKE_WAIT;
          end
        end
        ST_WAKE_WAIT: begin
          if (core_instr_done) begin
            state_reg <= ST_RUN;
          end
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  // Commands to the core sequencer
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_entry      <= 1'b0;
      vector_addr    <= 16'h0000;
      pc_pop         <= 1'b0;
      ctx_restore    <= 1'b0;
      restore_w      <= `RST_BYTE;
      restore_status <= `RST_BYTE;
      restore_bank_sel <= 5'h00;
      restore_pointers <= `RST_WORD;
      restore_pc_high  <= 7'h00;
      wake_req       <= 1'b0;
    end else begin
      // Flush, push and vector load are one pulse to the core
      irq_entry   <= take_irq;
      vector_addr <= `VECTOR_ADDR;
      pc_pop      <= core_return;
      ctx_restore <= core_return;
      if (core_return) begin
        restore_w        <= shadow_reg[`SH_W];
        restore_status   <= shadow_reg[`SH_STATUS];
        restore_bank_sel <= shadow_reg[`SH_BANK][4:0];
        restore_pointers <= {shadow_reg[`SH_PTR1_HI], shadow_reg[`SH_PTR1_LO],
                             shadow_reg[`SH_PTR0_HI], shadow_reg[`SH_PTR0_LO]};
        restore_pc_high  <= shadow_reg[`SH_PC_HIGH][6:0];
      end
      // Wake needs only the enables, not the global enable
      wake_req <= core_asleep & pending;
    end
  end

endmodule

`default_nettype wire

// file: irq_ctrl_consts.vh
// Constants for the processor interrupt controller: register byte
// offsets, field positions, reset values and fixed addresses.
// Assumes a 32-bit APB with byte addresses and word-aligned registers.
`ifndef IRQ_CTRL_CONSTS_VH
`define IRQ_CTRL_CONSTS_VH

// Register byte offsets
`define OFS_IRQ_CONTROL    8'h00
`define OFS_PERIPH_FLAG_A  8'h04
`define OFS_PERIPH_FLAG_B  8'h08
`define OFS_PERIPH_FLAG_C  8'h0C
`define OFS_PERIPH_EN_A    8'h10
`define OFS_PERIPH_EN_B    8'h14
`define OFS_PERIPH_EN_C    8'h18
`define OFS_EDGE_CFG       8'h1C
`define OFS_SHADOW_BASE    8'h20
`define OFS_SHADOW_LAST    8'h3C

// Shadow slot indices within the shadow block
`define SH_W         3'd0
`define SH_STATUS    3'd1
`define SH_BANK      3'd2
`define SH_PTR0_LO   3'd3
`define SH_PTR0_HI   3'd4
`define SH_PTR1_LO   3'd5
`define SH_PTR1_HI   3'd6
`define SH_PC_HIGH   3'd7

// Writable-bit masks of shadow slots (status keeps no time-out/power-down)
`define MASK_STATUS   8'h07
`define MASK_BANK     8'h1F
`define MASK_PC_HIGH  8'h7F
`define MASK_FULL     8'hFF

// Field positions of the control register
`define BIT_GLOBAL_EN    7
`define BIT_GROUP_EN     6
`define BIT_TIMER_EN     5
`define BIT_PIN_EN       4
`define BIT_CHANGE_EN    3
`define BIT_TIMER_FLAG   2
`define BIT_PIN_FLAG     1
`define BIT_CHANGE_FLAG  0

// Field position of the edge configuration register
`define BIT_EDGE_SEL  0

// Reset values and fixed addresses
`define RST_BYTE      8'h00
`define RST_WORD      32'h0000_0000
`define VECTOR_ADDR   16'h0004

`endif

// file: irq_ctrl_checker.sv
// Port checker for the interrupt controller.
// Assumes it is bound to cpu_interrupt_controller and sees its ports.
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_checker (
  // Clock and reset
  input wire        clk_sys,
  input wire        resetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  // Core side
  input wire        core_asleep,
  input wire        core_instr_done,
  input wire        core_return,
  input wire        irq_entry,
  input wire [15:0] vector_addr,
  input wire        pc_pop,
  input wire        ctx_restore,
  input wire [7:0]  restore_w,
  input wire [31:0] restore_pointers,
  input wire        wake_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  // Awake again but the first instruction has not finished
  sequence s_woke;
    $fell(core_asleep) ##0 !core_instr_done;
  endsequence
  a_entry_single: assert property (irq_entry |=> !irq_entry)
    else $error("entry pulse longer than one cycle");
  a_entry_vector: assert property (irq_entry |-> vector_addr == 16'h0004)
    else $error("entry without the fixed vector");
  a_sleep_blocks: assert property (core_asleep |=> !irq_entry)
    else $error("entry taken while asleep");
  a_wake_wait: assert property (s_woke |-> (!irq_entry) [*3])
    else $error("entry before the instruction after sleep");
  a_ret_pulse: assert property (core_return |=> pc_pop && ctx_restore)
    else $error("return not answered next cycle");
  a_pop_cause: assert property (pc_pop |-> $past(core_return))
    else $error("pop without a return");
  a_restore_hold: assert property (
    $changed(restore_w) || $changed(restore_pointers) |-> ctx_restore)
    else $error("restored context moved outside a return");
  a_wake_sleep: assert property (wake_req |-> $past(core_asleep))
    else $error("wake request while awake");
  a_setup_ready: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without a setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule
`default_nettype wire

// file: core_seq_model.sv
// Behavioural core sequencer facing the interrupt controller.
// Assumes bench commands are one-cycle pulses set after clk_sys edges.
`timescale 1ns/1ns
`default_nettype none
module core_seq_model (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         resetn,
  // Bench commands
  input  wire         sleep_cmd,
  input  wire         ret_cmd,
  input  wire  [7:0]  ctx_seed,
  // Controller side
  input  wire         wake_req,
  output logic        core_asleep,
  output logic        core_instr_done,
  output logic        core_return,
  output logic [7:0]  core_w,
  output logic [7:0]  core_status,
  output logic [4:0]  core_bank_sel,
  output logic [31:0] core_pointers,
  output logic [6:0]  core_pc_high
);
  logic [1:0] phase_reg;
  // Context follows a seed so the bench can predict every shadow
  assign core_w        = ctx_seed;
  assign core_status   = ~ctx_seed;
  assign core_bank_sel = ctx_seed[4:0];
  assign core_pointers = {4{ctx_seed}};
  assign core_pc_high  = ctx_seed[6:0];
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      core_asleep     <= 1'b0;
      core_instr_done <= 1'b0;
      core_return     <= 1'b0;
      phase_reg       <= 2'd0;
    end else begin
      core_return <= ret_cmd;
      if (sleep_cmd)
        core_asleep <= 1'b1;
      else if (wake_req)
        core_asleep <= 1'b0;
      // Slow first instruction after wake stresses the entry hold-off
      phase_reg       <= core_asleep ? 2'd0 : phase_reg + 2'd1;
      core_instr_done <= !core_asleep && phase_reg == 2'd3;
    end
  end
endmodule
`default_nettype wire

// file: cpu_interrupt_controller_test.sv
// Self-checking bench for the interrupt controller over APB.
// Assumes the core model and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module cpu_interrupt_controller_test;
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, ctx_seed, core_w, core_status, restore_w, restore_status;
  logic [31:0] pwdata, prdata, q, core_pointers, restore_pointers;
  logic [23:0] pev;
  logic tmr0_event, ioc_pending, ext_pin, sleep_cmd, ret_cmd, wake_req;
  logic core_asleep, core_instr_done, core_return, irq_entry, pc_pop;
  logic ctx_restore;
  logic [4:0] core_bank_sel, restore_bank_sel;
  logic [6:0] core_pc_high, restore_pc_high;
  logic [15:0] vector_addr;
  int fail_count = 0, compares = 0, n_entry = 0, lat, base;
  cpu_interrupt_controller dut (
    .clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tmr0_event, .ioc_pending, .periph_event_a(pev[7:0]),
    .periph_event_b(pev[15:8]), .periph_event_c(pev[23:16]), .ext_pin,
    .core_asleep, .core_instr_done, .core_return, .core_w, .core_status,
    .core_bank_sel, .core_pointers, .core_pc_high, .irq_entry, .vector_addr,
    .pc_pop, .ctx_restore, .restore_w, .restore_status, .restore_bank_sel,
    .restore_pointers, .restore_pc_high, .wake_req);
  core_seq_model core (
    .clk_sys, .resetn, .sleep_cmd, .ret_cmd, .ctx_seed, .wake_req,
    .core_asleep, .core_instr_done, .core_return, .core_w, .core_status,
    .core_bank_sel, .core_pointers, .core_pc_high);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (irq_entry === 1'b1) n_entry <= n_entry + 1;
  task automatic check(input string nm, input logic [31:0] s, x);
    compares++;
    if (s !== x) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // No local limit: a slave that never answers is ended by the watchdog
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, x, input string nm);
    apb(1'b0, a, 8'h00);
    check(nm, q, {24'h00_0000, x});
  endtask
  // One-cycle strobe: 0 timer event, 1 return, 2 sleep
  task automatic pulse(input int s);
    @(posedge clk_sys);
    {sleep_cmd, ret_cmd, tmr0_event} <= 3'(1 << s);
    @(posedge clk_sys);
    {sleep_cmd, ret_cmd, tmr0_event} <= 3'h0;
  endtask
  task automatic wait_entry(input int k);
    for (int i = 0; i < 40 && n_entry != k; i++) @(posedge clk_sys);
    check("entries", n_entry, k);
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #80000;
    fail_count++;
    give_verdict();
  end
  initial begin
    {psel, penable, pwrite, tmr0_event, ioc_pending} = 5'h00;
    {sleep_cmd, ret_cmd, resetn, ext_pin} = 4'h1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pev = 24'h00_0000;
    ctx_seed = 8'hA5;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'h00, 8'h00, "control");
    rd(8'h10, 8'h00, "enable_a");
    check("vector", vector_addr, 16'h0004);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      pev <= 24'h00_0001 << (9 * k);
      @(posedge clk_sys);
      pev <= 24'h00_0000;
      rd(8'h04 + 8'(4 * k), 8'(1 << k), "flag");
    end
    pulse(0);
    wr(8'h10, 8'h01);
    wr(8'h00, 8'h84);
    rd(8'h00, 8'h84, "control");
    repeat (8) @(posedge clk_sys);
    check("entries", n_entry, 0);
    wr(8'h00, 8'hC4);
    wait_entry(1);
    rd(8'h00, 8'h44, "control");
    rd(8'h20, 8'hA5, "shadow_w");
    rd(8'h24, 8'h02, "shadow_status");
    rd(8'h3C, 8'h25, "shadow_pc_high");
    $display("test entry done");
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h40);
    wr(8'h20, 8'h33);
    pulse(1);
    repeat (3) @(posedge clk_sys);
    check("restore_w", restore_w, 8'h33);
    check("restore_status", restore_status[2:0], 3'h2);
    check("restore_pointers", restore_pointers, 32'hA5A5_A5A5);
    check("restore_bank", restore_bank_sel, 5'h05);
    check("restore_pc_high", restore_pc_high, 7'h25);
    rd(8'h00, 8'hC0, "control");
    check("entries", n_entry, 1);
    wr(8'h00, 8'hA0);
    pulse(0);
    lat = 0;
    do begin
      @(posedge clk_sys);
      lat++;
    end while (irq_entry !== 1'b1 && lat < 20);
    check("latency", lat, 2);
    $display("test return done");
    ioc_pending <= 1'b1;
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h01, "control");
    ioc_pending <= 1'b0;
    rd(8'h40, 8'h00, "unmapped");
    check("slverr", e, 1'b1);
    wr(8'h02, 8'hFF);
    check("slverr", e, 1'b1);
    for (int g = 0; g < 2; g++) begin
      wr(8'h1C, 8'(g));
      ext_pin <= (g == 0);
      repeat (6) @(posedge clk_sys);
      wr(8'h00, 8'h10);
      rd(8'h00, 8'h10, "control");
      ext_pin <= (g == 1);
      repeat (6) @(posedge clk_sys);
      rd(8'h00, 8'h12, "control");
    end
    wr(8'h00, 8'h90);
    wr(8'h1C, 8'h00);
    ext_pin <= 1'b0;
    wait_entry(3);
    $display("test pin done");
    for (int g = 0; g < 2; g++) begin
      base = n_entry;
      wr(8'h00, g ? 8'hA0 : 8'h20);
      pulse(2);
      pulse(0);
      repeat (20) @(posedge clk_sys);
      check("asleep", core_asleep, 1'b0);
      check("entries", n_entry, base + g);
    end
    $display("test sleep done");
    give_verdict();
  end
endmodule
bind cpu_interrupt_controller irq_ctrl_checker chk (
  .clk_sys, .resetn, .psel, .penable, .pready, .pslverr, .core_asleep,
  .core_instr_done, .core_return, .irq_entry, .vector_addr, .pc_pop,
  .ctx_restore, .restore_w, .restore_pointers, .wake_req);
`default_nettype wire
